// ==== radio_packet_link_layer_tb.sv ====
// radio_packet_link_layer_tb: register traffic, frame capture and retry checks.
// assumes rpl_link with short step and listen counts and a silent peer.
`timescale 1ns/1ps
module radio_packet_link_layer_tb import rpl_pkg::*;;
  logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, rd_q = 0;
  logic air_rx_bit_i, air_rx_valid_i, air_tx_bit_o, air_tx_en_o, standby_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
  logic [6:0] channel_o;
  logic [127:0] fr, ex;
  logic [15:0] pay;
  logic [1:0] tg, tag1;
  logic [7:0] exp_q[$];
  int miscompares = 0, check_count = 0, frames, seed = 32'h57fd833f;
  rpl_link #(.STEP_CYC(200), .LISTEN_CYC(150)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .air_tx_bit_o(air_tx_bit_o), .air_tx_en_o(air_tx_en_o),
    .air_rx_bit_i(air_rx_bit_i), .air_rx_valid_i(air_rx_valid_i), .standby_o(standby_o),
    .channel_o(channel_o));
  rpl_peer peer (.clk_i(clk_i), .tx_bit_i(air_tx_bit_o), .tx_en_i(air_tx_en_o),
    .rx_bit_o(air_rx_bit_i), .rx_valid_o(air_rx_valid_i), .frame_o(fr), .frames_o(frames));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task chk(string n, logic [63:0] s, logic [63:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish();
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  // waits for frame n to end on air
  task wait_tx(int n);
    for (int i = 0; i < 20000 && !(frames == n && !air_tx_en_o); i++)
      @(posedge clk_i);
    repeat (10) @(posedge clk_i);
  endtask
  // expected frame: preamble, address, control, payload, crc8 msb first
  function logic [127:0] frm(logic [15:0] p, logic [1:0] t);
    logic [64:0] d;
    logic [7:0] c;
    d = {ADDR_RST, 6'h02, t, 1'b0, p};
    c = 8'hFF;
    for (int i = 64; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return {ADDR_RST[39] ? 8'hAA : 8'h55, d, c, 47'h0};
  endfunction
  // read data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q)
      chk("rdata", reg_rdata_o, exp_q.pop_front());
  end
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(REG_RETRY_SETUP, 8'h03);
    rd(REG_ADDR_WIDTH, 8'h03);
    wr(REG_FEATURE, 8'h0A);
    wr(REG_RETRY_SETUP, 8'h01);
    for (int k = 0; k < 2; k++) begin
      pay = 16'($random(seed));
      wr(REG_TX_DATA, pay[15:8]);
      wr(REG_TX_DATA, pay[7:0]);
      wr(REG_TX_COMMIT, 8'h00);
      wr(REG_CONFIG, 8'h04);
      wait_tx(k + 1);
      tg = fr[73:72];
      ex = frm(pay, tg);
      chk("frame_hi", fr[127:64], ex[127:64]);
      chk("frame_lo", fr[63:0], ex[63:0]);
      if (k)
        chk("tag", tg, tag1 + 2'h1);
      tag1 = tg;
      rd(REG_STATUS, 8'h02);
      wr(REG_STATUS, 8'h02);
    end
    wr(REG_CONFIG, 8'h00);
    repeat (3) @(posedge clk_i);
    chk("standby", standby_o, 1'b1);
    // auto reply on with a silent peer: one retry, then exhausted
    wr(REG_FEATURE, 8'h0E);
    wr(REG_TX_DATA, 8'(seed));
    wr(REG_TX_COMMIT, 8'h00);
    wr(REG_CONFIG, 8'h04);
    wait_tx(4);
    repeat (300) @(posedge clk_i);
    chk("frames", frames, 4);
    rd(REG_TX_OBSERVATION, 8'h11);
    rd(REG_STATUS, 8'h11);
    wr(REG_CHANNEL_SELECT, 8'h05);
    rd(REG_TX_OBSERVATION, 8'h01);
    chk("channel", channel_o, 7'h05);
    // nothing received: length reads zero, host flushes the receive side
    rd(REG_RX_LENGTH, 8'h00);
    wr(REG_COMMAND, 8'h02);
    // repeat mode: one frame per fresh active pulse, slot kept
    wr(REG_CONFIG, 8'h00);
    wr(REG_COMMAND, 8'h04);
    wr(REG_FEATURE, 8'h0A);
    wr(REG_STATUS, 8'h01);
    wr(REG_CONFIG, 8'h04);
    wait_tx(5);
    repeat (300) @(posedge clk_i);
    chk("frames_rep", frames, 5);
    rd(REG_STATUS, 8'h12);
    repeat (3) @(posedge clk_i);
    tally_and_finish();
  end
endmodule

// ==== rpl_link.sv ====
// rpl_link: packet assembly, disassembly, auto reply and auto retry of the radio link layer.
// assumes the modem gives one received bit per air_rx_valid_i pulse and sends one bit per BIT_DIV clock cycles.
`timescale 1ns/1ps

module rpl_link import rpl_pkg::*; #(
  parameter int STEP_CYC = STEP_CYC_DEF,
  parameter int LISTEN_CYC = LISTEN_CYC_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // air side
  output logic air_tx_bit_o,
  output logic air_tx_en_o,
  input wire logic air_rx_bit_i,
  input wire logic air_rx_valid_i,
  // status
  output logic standby_o,
  output logic [6:0] channel_o
);

  typedef struct packed {
    rpl_state_t st;
    logic standby;
    logic primary_receiver;
    logic crc2;
    logic active;
    logic act_prev;
    logic [1:0] aw;
    logic [3:0] retry_delay;
    logic [3:0] retry_limit;
    logic [6:0] ch;
    logic [3:0] lost;
    logic [3:0] rcnt;
    logic irq_max;
    logic irq_txd;
    logic irq_rxd;
    logic rpe;
    logic dple;
    logic aae;
    logic dpp;
    logic [5:0] srw;
    logic [39:0] addr;
    logic [95:0][7:0] txm;
    logic [2:0][5:0] tlen;
    logic [2:0][1:0] ttag;
    logic [2:0] tskip;
    logic [1:0] thead;
    logic [1:0] tcnt;
    logic [5:0] tfill;
    logic [1:0] seq;
    logic reuse;
    logic [31:0][7:0] rxm;
    logic [5:0] rlen;
    logic ravail;
    logic [5:0] rptr;
    logic [1:0] last_tag;
    logic [15:0] last_crc;
    logic have_last;
    logic room;
    logic [7:0] rdata;
    logic [7:0] div;
    logic tbit;
    logic ten;
    logic [9:0] bitpos;
    logic [15:0] crc;
    logic [39:0] rxsh;
    logic [8:0] rctl;
    logic [15:0] rcrc;
    logic [7:0] rbyte;
    logic [19:0] tmr;
    logic ack_mode;
    logic [5:0] ack_len;
    logic [1:0] ack_tag;
  } rpl_regs_t;

  // one crc step, msb first, no final inversion
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic two);
    logic fb;
    fb = two ? (c[15] ^ b) : (c[7] ^ b);
    if (two) begin
      crc_step = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
    end else begin
      crc_step = {8'h00, c[6:0], 1'b0} ^ {8'h00, (fb ? CRC8_POLY : 8'h00)};
    end
  endfunction

  // address field length in bits
  function automatic logic [9:0] addr_bits(input logic [1:0] aw);
    case (aw)
      2'h2: addr_bits = 10'h020;
      2'h3: addr_bits = 10'h028;
      default: addr_bits = 10'h018;
    endcase
  endfunction

  // crc seeded with its initial value and run over the address bits
  function automatic logic [15:0] crc_addr(input logic [39:0] a, input logic [9:0] n, input logic two);
    logic [15:0] c;
    c = two ? CRC16_INIT : {8'h00, CRC8_INIT};
    for (int i = 39; i >= 0; i--) begin
      if (10'(i) < n) begin
        c = crc_step(c, a[i], two);
      end
    end
    return c;
  endfunction

  // index into the three-slot transmit memory
  function automatic logic [6:0] mem_idx(input logic [1:0] slot, input logic [5:0] bi);
    return {slot, 5'h00} + {2'h0, bi[4:0]};
  endfunction

  // slot arithmetic modulo three
  function automatic logic [1:0] add3(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s >= {1'b0, TX_SLOTS}) ? 2'(s - {1'b0, TX_SLOTS}) : s[1:0];
  endfunction

  // begin a packet: payload stays that of the head slot, tag is the head slot's or, in ack mode, ack_tag
  function automatic rpl_regs_t start_tx(input rpl_regs_t s, input logic ackm);
    start_tx = s;
    start_tx.st = S_TX;
    start_tx.bitpos = 10'h000;
    start_tx.div = 8'h00;
    start_tx.ack_mode = ackm;
    start_tx.crc = crc_addr(s.addr, addr_bits(s.aw), s.crc2);
  endfunction

  // drop the head slot of the transmit queue
  function automatic rpl_regs_t pop_tx(input rpl_regs_t s);
    pop_tx = s;
    if (s.tcnt != 2'h0) begin
      pop_tx.thead = add3(s.thead, 2'h1);
      pop_tx.tcnt = s.tcnt - 2'h1;
    end
  endfunction

  function automatic rpl_regs_t reset_value();
    reset_value = '0;
    reset_value.st = S_IDLE;
    reset_value.standby = 1'b1;
    reset_value.aw = AW_RST;
    reset_value.retry_delay = DELAY_RST;
    reset_value.retry_limit = LIMIT_RST;
    reset_value.ch = CH_RST;
    reset_value.addr = ADDR_RST;
  endfunction

  localparam rpl_regs_t Q_RST = reset_value();

  rpl_regs_t q, d;
  logic tick, start_pulse, out_bit, match, vlen, rx_end, rx_ok, dup, deliver;
  logic [9:0] ab, a_end, c_end, p_end, k_end, cb, off, t, r_end, pidx;
  logic [5:0] tx_len, plen;
  logic [1:0] tx_tag, fslot;
  logic tx_skip;
  logic [8:0] ctrl9;
  logic [15:0] sh, crc_n, rcrc_n, cmp;
  logic [39:0] mask, nsh;
  logic [19:0] dly;
  logic [7:0] rval;
  logic [5:0] stored;

  // frame geometry and next bit of the outgoing packet
  always_comb begin
    tick = (q.div == 8'(BIT_DIV - 1));
    start_pulse = q.active && !q.act_prev;
    ab = addr_bits(q.aw);
    cb = q.crc2 ? 10'd16 : 10'd8;
    tx_len = q.ack_mode ? q.ack_len : q.tlen[q.thead];
    tx_tag = q.ack_mode ? q.ack_tag : q.ttag[q.thead];
    tx_skip = q.ack_mode ? 1'b0 : q.tskip[q.thead];
    ctrl9 = {tx_len, tx_tag, tx_skip};
    a_end = 10'd8 + ab;
    c_end = a_end + 10'd9;
    p_end = c_end + {1'b0, tx_len, 3'b000};
    k_end = p_end + cb;
    off = q.bitpos - c_end;
    t = ab - 10'd1 - (q.bitpos - 10'd8);
    sh = q.crc << 4'(q.bitpos - p_end);
    if (q.bitpos < 10'd8) begin
      out_bit = (q.addr[6'(ab - 10'd1)] ? PRE_ONE[3'(10'd7 - q.bitpos)] : PRE_ZERO[3'(10'd7 - q.bitpos)]);
    end else if (q.bitpos < a_end) begin
      out_bit = q.addr[t[5:0]];
    end else if (q.bitpos < c_end) begin
      out_bit = ctrl9[4'(10'd8 - (q.bitpos - a_end))];
    end else if (q.bitpos < p_end) begin
      out_bit = q.txm[mem_idx(q.thead, off[8:3])][3'h7 - off[2:0]];
    end else begin
      out_bit = q.crc2 ? sh[15] : sh[7];
    end
    dly = 20'((32'(q.retry_delay) + 32'd1) * STEP_CYC);
    fslot = add3(q.thead, q.tcnt);
    stored = (q.rlen > 6'(MAX_PAY)) ? 6'(MAX_PAY) : q.rlen;
  end

  // receive side decode
  always_comb begin
    nsh = {q.rxsh[38:0], air_rx_bit_i};
    mask = ~(40'hFFFFFFFFFF << ab);
    match = ((nsh ^ q.addr) & mask) == 40'h0000000000;
    vlen = q.primary_receiver ? (q.dple && q.dpp) : q.dple;
    plen = vlen ? q.rctl[8:3] : (q.primary_receiver ? q.srw : 6'h00);
    r_end = 10'd9 + {1'b0, plen, 3'b000} + cb;
    pidx = q.bitpos - 10'd9;
    crc_n = crc_step(q.crc, air_rx_bit_i, q.crc2);
    rcrc_n = {q.rcrc[14:0], air_rx_bit_i};
    cmp = q.crc2 ? rcrc_n : {8'h00, rcrc_n[7:0]};
    rx_end = air_rx_valid_i && (q.bitpos == r_end - 10'd1);
    rx_ok = q.crc2 ? (crc_n == 16'h0000) : (crc_n[7:0] == 8'h00);
    dup = q.aae && q.have_last && (q.rctl[2:1] == q.last_tag) && (cmp == q.last_crc);
    deliver = rx_ok && q.room && (q.primary_receiver ? !dup : (plen != 6'h00));
  end

  // next state: register port first, link engine after it so hardware sets win
  always_comb begin
    d = q;
    rval = 8'h00;
    d.act_prev = q.active;
    d.div = tick ? 8'h00 : q.div + 8'h01;
    if (reg_wr_i) begin
      if (reg_addr_i == REG_CONFIG) begin
        d.primary_receiver = reg_wdata_i[CFG_PRX];
        d.crc2 = reg_wdata_i[CFG_CRC2];
        d.active = reg_wdata_i[CFG_ACTIVE];
      end else if (reg_addr_i == REG_ADDR_WIDTH) begin
        d.aw = reg_wdata_i[1:0];
      end else if (reg_addr_i == REG_RETRY_SETUP) begin
        d.retry_delay = reg_wdata_i[7:4];
        d.retry_limit = reg_wdata_i[3:0];
      end else if (reg_addr_i == REG_CHANNEL_SELECT) begin
        d.ch = reg_wdata_i[6:0];
        d.lost = 4'h0;
      end else if (reg_addr_i == REG_STATUS) begin
        d.irq_max = q.irq_max && !reg_wdata_i[0];
        d.irq_txd = q.irq_txd && !reg_wdata_i[1];
        d.irq_rxd = q.irq_rxd && !reg_wdata_i[2];
      end else if (reg_addr_i == REG_FEATURE) begin
        d.rpe = reg_wdata_i[FEAT_REPLY];
        d.dple = reg_wdata_i[FEAT_VLEN];
        d.aae = reg_wdata_i[FEAT_AUTO];
        d.dpp = reg_wdata_i[FEAT_PIPE0];
      end else if (reg_addr_i == REG_STATIC_RX_WIDTH) begin
        d.srw = reg_wdata_i[5:0];
      end else if (reg_addr_i >= REG_ADDR0 && reg_addr_i <= REG_ADDR4) begin
        d.addr[{3'(reg_addr_i - REG_ADDR0), 3'h0} +: 8] = reg_wdata_i;
      end else if (reg_addr_i == REG_TX_DATA) begin
        if (q.tcnt < TX_SLOTS && q.tfill < 6'(MAX_PAY)) begin
          d.txm[mem_idx(fslot, q.tfill)] = reg_wdata_i;
          d.tfill = q.tfill + 6'h01;
        end
      end else if (reg_addr_i == REG_TX_COMMIT) begin
        if (q.tcnt < TX_SLOTS) begin
          d.tlen[fslot] = q.tfill;
          d.ttag[fslot] = q.seq + 2'h1;
          d.tskip[fslot] = reg_wdata_i[0];
          d.seq = q.seq + 2'h1;
          d.tcnt = q.tcnt + 2'h1;
          d.tfill = 6'h00;
          d.reuse = 1'b0;
        end
      end else if (reg_addr_i == REG_COMMAND) begin
        if (reg_wdata_i[CMD_FLUSH_TX]) begin
          d.tcnt = 2'h0;
          d.thead = 2'h0;
          d.tfill = 6'h00;
          d.reuse = 1'b0;
        end
        if (reg_wdata_i[CMD_FLUSH_RX]) begin
          d.ravail = 1'b0;
          d.rptr = 6'h00;
        end
        if (reg_wdata_i[CMD_REPEAT]) begin
          d.reuse = 1'b1;
        end
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == REG_CONFIG) begin
        rval = {5'h00, q.active, q.crc2, q.primary_receiver};
      end else if (reg_addr_i == REG_ADDR_WIDTH) begin
        rval = {6'h00, q.aw};
      end else if (reg_addr_i == REG_RETRY_SETUP) begin
        rval = {q.retry_delay, q.retry_limit};
      end else if (reg_addr_i == REG_CHANNEL_SELECT) begin
        rval = {1'b0, q.ch};
      end else if (reg_addr_i == REG_TX_OBSERVATION) begin
        rval = {q.lost, q.rcnt};
      end else if (reg_addr_i == REG_STATUS) begin
        rval = {2'h0, q.tcnt, q.ravail, q.irq_rxd, q.irq_txd, q.irq_max};
      end else if (reg_addr_i == REG_FEATURE) begin
        rval = {4'h0, q.dpp, q.aae, q.dple, q.rpe};
      end else if (reg_addr_i == REG_STATIC_RX_WIDTH) begin
        rval = {2'h0, q.srw};
      end else if (reg_addr_i >= REG_ADDR0 && reg_addr_i <= REG_ADDR4) begin
        rval = q.addr[{3'(reg_addr_i - REG_ADDR0), 3'h0} +: 8];
      end else if (reg_addr_i == REG_RX_DATA) begin
        if (q.ravail) begin
          rval = q.rxm[q.rptr[4:0]];
          d.rptr = q.rptr + 6'h01;
          d.ravail = (q.rptr + 6'h01) < stored;
        end
      end else if (reg_addr_i == REG_RX_LENGTH) begin
        rval = {2'h0, q.rlen};
      end
    end
    d.rdata = rval;
    case (q.st)
      S_IDLE: begin
        d.ten = 1'b0;
        if (q.primary_receiver) begin
          if (q.active) begin
            d.st = S_LISTEN;
            d.rxsh = 40'h0000000000;
          end
        end else if (q.active && q.tcnt != 2'h0 && !q.irq_max && (!q.reuse || start_pulse)) begin
          d = start_tx(d, 1'b0);
          d.rcnt = 4'h0;
        end
      end
      S_TX: begin
        if (tick) begin
          if (q.bitpos < k_end) begin
            d.ten = 1'b1;
            d.tbit = out_bit;
            if (q.bitpos >= a_end && q.bitpos < p_end) begin
              d.crc = crc_step(q.crc, out_bit, q.crc2);
            end
            d.bitpos = q.bitpos + 10'd1;
          end else begin
            d.ten = 1'b0;
            d.tbit = 1'b0;
            d.tmr = 20'h00000;
            d.rxsh = 40'h0000000000;
            if (q.ack_mode) begin
              if (q.ack_len != 6'h00) begin
                d = pop_tx(d);
              end
              d.st = S_LISTEN;
            end else if (tx_skip || !q.aae) begin
              d.irq_txd = 1'b1;
              if (!q.reuse) begin
                d = pop_tx(d);
              end
              d.st = S_IDLE;
            end else begin
              d.st = S_LISTEN;
            end
          end
        end
      end
      S_LISTEN: begin
        d.tmr = q.tmr + 20'h00001;
        if (air_rx_valid_i) begin
          d.rxsh = nsh;
        end
        if (air_rx_valid_i && match) begin
          d.st = S_RXD;
          d.bitpos = 10'h000;
          d.crc = crc_addr(q.addr, ab, q.crc2);
          d.room = !q.ravail;
        end else if (q.primary_receiver) begin
          if (!q.active) begin
            d.st = S_IDLE;
          end
        end else if (q.tmr >= 20'(LISTEN_CYC) || q.tmr >= dly) begin
          d.st = S_WAIT;
        end
      end
      S_RXD: begin
        d.tmr = q.tmr + 20'h00001;
        if (air_rx_valid_i) begin
          d.bitpos = q.bitpos + 10'd1;
          d.crc = crc_n;
          if (q.bitpos < 10'd9) begin
            d.rctl = {q.rctl[7:0], air_rx_bit_i};
          end else if (q.bitpos < 10'd9 + {1'b0, plen, 3'b000}) begin
            d.rbyte = {q.rbyte[6:0], air_rx_bit_i};
            if (pidx[2:0] == 3'h7 && pidx[9:3] < 7'd32 && q.room) begin
              d.rxm[pidx[7:3]] = {q.rbyte[6:0], air_rx_bit_i};
            end
          end else begin
            d.rcrc = rcrc_n;
          end
        end
        if (rx_end) begin
          if (deliver) begin
            d.rlen = plen;
            d.ravail = 1'b1;
            d.rptr = 6'h00;
            d.irq_rxd = 1'b1;
          end
          if (q.primary_receiver) begin
            d.st = S_LISTEN;
            if (rx_ok && (dup || deliver)) begin
              d.last_tag = q.rctl[2:1];
              d.last_crc = cmp;
              d.have_last = 1'b1;
              if (q.aae && !q.rctl[0]) begin
                d = start_tx(d, 1'b1);
                d.ack_tag = q.rctl[2:1];
                d.ack_len = (q.rpe && q.tcnt != 2'h0) ? q.tlen[q.thead] : 6'h00;
              end
            end
          end else if (rx_ok) begin
            d.irq_txd = 1'b1;
            if (!q.reuse) begin
              d = pop_tx(d);
            end
            d.st = S_IDLE;
          end else begin
            d.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        d.tmr = q.tmr + 20'h00001;
        if (q.tmr >= dly) begin
          if (q.rcnt >= q.retry_limit) begin
            d.irq_max = 1'b1;
            d.st = S_IDLE;
          end else begin
            d = start_tx(d, 1'b0);
            d.rcnt = q.rcnt + 4'h1;
            d.lost = (q.lost == 4'hF) ? q.lost : q.lost + 4'h1;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    d.standby = (d.st == S_IDLE);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign air_tx_bit_o = q.tbit;
  assign air_tx_en_o = q.ten;
  assign standby_o = q.standby;
  assign channel_o = q.ch;

  default clocking cb_main @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // preamble opens with the first address bit
  a_preamble_pattern: assert property ($rose(air_tx_en_o) |-> air_tx_bit_o == q.addr[6'(ab - 10'd1)])
    else $error("preamble does not follow first address bit");
  // crc seeded over the address at packet start
  a_crc_seed: assert property ($rose(q.st == S_TX) |-> q.crc == crc_addr(q.addr, ab, q.crc2))
    else $error("crc seed wrong at packet start");
  // tag advances on every accepted commit
  a_tag_advance: assert property (reg_wr_i && reg_addr_i == REG_TX_COMMIT && q.tcnt < TX_SLOTS
    |=> q.seq == $past(q.seq) + 2'h1)
    else $error("sequence tag did not advance");
  // exhausted flag only at the retry limit
  a_retry_limit: assert property ($rose(q.irq_max) |-> $past(q.rcnt) >= $past(q.retry_limit) && q.st == S_IDLE)
    else $error("retry exhausted raised below limit");
  // channel write outside the retry wait clears total loss count
  a_lost_clear: assert property (reg_wr_i && reg_addr_i == REG_CHANNEL_SELECT && q.st != S_WAIT
    |=> q.lost == 4'h0)
    else $error("loss count not cleared by channel write");
  // no reply when the skip flag is set
  a_skip_reply: assert property (q.primary_receiver && q.st == S_TX && $past(q.st) == S_RXD |-> !q.rctl[0])
    else $error("reply sent despite skip flag");
  // delivery only after a good crc
  a_crc_reject: assert property ($rose(q.ravail) |-> $past(rx_end && rx_ok))
    else $error("packet delivered without valid crc");
  // idle with radio inactive stays idle
  a_idle_stay: assert property (q.st == S_IDLE && !q.active |=> q.st == S_IDLE && standby_o)
    else $error("left standby with radio inactive");
  // sender listen window bounded
  a_listen_window: assert property (!q.primary_receiver && q.st == S_LISTEN |-> q.tmr <= 20'(LISTEN_CYC))
    else $error("listen window overran");

  c_retry_exhausted: cover property ($rose(q.irq_max));
  c_reply_payload: cover property ($rose(q.irq_txd) && $rose(q.irq_rxd));
  c_prx_reply: cover property (q.primary_receiver && q.st == S_RXD ##1 q.st == S_TX);
  c_retransmit: cover property (q.st == S_WAIT ##1 q.st == S_TX);

endmodule

// ==== rpl_peer.sv ====
// rpl_peer: silent peer radio that records the bits it sees on air.
// assumes one bit per BIT_DIV cycles, starting at the enable rise.
`timescale 1ns/1ps
module rpl_peer import rpl_pkg::*; (
  // air side
  input wire logic clk_i,
  input wire logic tx_bit_i,
  input wire logic tx_en_i,
  output logic rx_bit_o,
  output logic rx_valid_o,
  // capture, first bit in bit 127
  output logic [127:0] frame_o,
  output int frames_o
);
  int ph = 0;
  int idx = 0;
  logic en_q = 1'b0;
  initial begin
    rx_bit_o = 1'b0;
    rx_valid_o = 1'b0;
    frames_o = 0;
    frame_o = '0;
  end
  // undriven line toggles; samples land mid bit
  always @(posedge clk_i) begin
    rx_bit_o <= ~rx_bit_o;
    en_q <= tx_en_i;
    ph <= tx_en_i ? (ph + 1) % BIT_DIV : 0;
    if (tx_en_i && !en_q) begin
      frames_o <= frames_o + 1;
      idx <= 0;
      frame_o <= '0;
    end else if (tx_en_i && ph == BIT_DIV / 2 && idx < 128) begin
      frame_o[127 - idx] <= tx_bit_i;
      idx <= idx + 1;
    end
  end
endmodule

// ==== rpl_pkg.sv ====
// rpl_pkg: constants, register map and state encoding of the radio packet link layer.
// assumes a 100 MHz core clock and a bit-serial modem on the air side.
package rpl_pkg;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int RETRY_STEP_US = 250;
  localparam int LISTEN_US = 250;
  localparam int STEP_CYC_DEF = RETRY_STEP_US * CLK_MHZ;
  localparam int LISTEN_CYC_DEF = LISTEN_US * CLK_MHZ;
  localparam int AIR_KBPS = 1000;
  localparam int BIT_DIV = CLK_MHZ * 1000 / AIR_KBPS;

  // sizes
  localparam int MAX_PAY = 32;
  localparam logic [1:0] TX_SLOTS = 2'h3;

  // register offsets
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_ADDR_WIDTH = 8'h01;
  localparam logic [7:0] REG_RETRY_SETUP = 8'h02;
  localparam logic [7:0] REG_CHANNEL_SELECT = 8'h03;
  localparam logic [7:0] REG_TX_OBSERVATION = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;
  localparam logic [7:0] REG_FEATURE = 8'h06;
  localparam logic [7:0] REG_STATIC_RX_WIDTH = 8'h07;
  localparam logic [7:0] REG_ADDR0 = 8'h08;
  localparam logic [7:0] REG_ADDR4 = 8'h0C;
  localparam logic [7:0] REG_TX_DATA = 8'h10;
  localparam logic [7:0] REG_TX_COMMIT = 8'h11;
  localparam logic [7:0] REG_COMMAND = 8'h12;
  localparam logic [7:0] REG_RX_DATA = 8'h13;
  localparam logic [7:0] REG_RX_LENGTH = 8'h14;

  // field positions
  localparam int CFG_PRX = 0;
  localparam int CFG_CRC2 = 1;
  localparam int CFG_ACTIVE = 2;
  localparam int FEAT_REPLY = 0;
  localparam int FEAT_VLEN = 1;
  localparam int FEAT_AUTO = 2;
  localparam int FEAT_PIPE0 = 3;
  localparam int CMD_FLUSH_TX = 0;
  localparam int CMD_FLUSH_RX = 1;
  localparam int CMD_REPEAT = 2;

  // reset values
  localparam logic [1:0] AW_RST = 2'h3;
  localparam logic [3:0] DELAY_RST = 4'h0;
  localparam logic [3:0] LIMIT_RST = 4'h3;
  localparam logic [6:0] CH_RST = 7'h02;
  localparam logic [39:0] ADDR_RST = 40'hA5A5A5A5A5;

  // framing and crc
  localparam logic [7:0] PRE_ONE = 8'hAA;
  localparam logic [7:0] PRE_ZERO = 8'h55;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [7:0] CRC8_INIT = 8'hFF;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_TX = 5'h02,
    S_LISTEN = 5'h04,
    S_RXD = 5'h08,
    S_WAIT = 5'h10
  } rpl_state_t;

endpackage
